// ---- rtl/clbp_defines.vh ----
// Constants for the control and bulk list pointer registers
`ifndef CLBP_DEFINES_VH
`define CLBP_DEFINES_VH

`define CLBP_OFS_CTRL_CUR   8'h24
`define CLBP_OFS_BULK_HEAD  8'h28
`define CLBP_PTR_RESET      32'h00000000
`define CLBP_FIELD_RESET    28'h0000000
`define CLBP_FIELD_HI       31
`define CLBP_FIELD_LO       4
`define CLBP_RSVD_ZERO      4'h0
`define CLBP_CLF_BIT        1
`define CLBP_CLE_BIT        4

`define CLBP_ST_IDLE        2'h0
`define CLBP_ST_WALK        2'h1
`define CLBP_ST_END         2'h2

`endif

// ---- rtl/clbp_reg_slice.v ----
// Pointer field register with load and software write paths
`timescale 1ns/1ps
module clbp_reg_slice
#(
  parameter W = 28
)
(
  // Clock and reset
  input  wire         core_clk,
  input  wire         rst_n,
  // Update paths, hardware load has priority
  input  wire         hw_load,
  input  wire [W-1:0] hw_value,
  input  wire         sw_load,
  input  wire [W-1:0] sw_value,
  // Stored field
  output reg  [W-1:0] field_r
);
  reg [W-1:0] field_nxt;

  always @*
  begin
    field_nxt = field_r;
    if (sw_load)
      field_nxt = sw_value;
    if (hw_load)
      field_nxt = hw_value;
  end

  always @(posedge core_clk)
  begin
    if (!rst_n)
      field_r <= {W{1'b0}};
    else
      field_r <= field_nxt;
  end
endmodule

// ---- rtl/clbp_list_pointers.v ----
// Control current and bulk head list pointer register bank
// Functional notes
// - After serving the current control descriptor the pointer moves to the next one.
// - Each frame resumes control processing where the last frame stopped.
// - At the end of the control list the control-list-filled flag is examined.
// - With the flag set the pointer reloads from the head pointer and the flag clears.
// - With the flag clear nothing changes at the end of the list.
// - While enabled, reads return the live pointer and writes to the control current pointer are not taken; bulk head writes are.
// - The control current pointer resets to zero, and zero marks end of list.
// - Every bulk list traversal starts at the bulk head pointer.
// - During initialisation the bulk head is loaded from the communication area.
// - Each pointer is 32 bits with address in 31..4 and bits 3..0 reserved.
`timescale 1ns/1ps
`include "clbp_defines.vh"
module clbp_list_pointers
#(
  parameter FW = 28
)
(
  // Clock and reset
  input  wire          core_clk,
  input  wire          rst_n,
  // Register port
  input  wire [7:0]    reg_addr,
  input  wire          reg_wr,
  input  wire          reg_rd,
  input  wire [31:0]   reg_wdata,
  output reg  [31:0]   reg_rdata,
  // Related control and status bits
  input  wire [31:0]   host_control_register,
  input  wire          control_list_filled,
  output reg           clf_clear,
  input  wire [31:0]   control_list_head_pointer,
  // List engine events
  input  wire          frame_start,
  input  wire          ed_served,
  input  wire [31:0]   ed_next_pointer,
  input  wire          bulk_start,
  // Initialisation load from communication area
  input  wire          init_load,
  input  wire [31:0]   init_bulk_head,
  // Descriptor addresses for the list engine
  output reg  [31:0]   control_ed_addr,
  output reg  [31:0]   bulk_ed_addr,
  output reg           control_list_end,
  output reg           control_active
);

  // Field plus four zero bits gives a 16-byte aligned address
  function [31:0] ed_addr;
    input [FW-1:0] fld;
    begin
      ed_addr = {fld, `CLBP_RSVD_ZERO};
    end
  endfunction

  function [FW-1:0] ptr_field;
    input [31:0] v;
    begin
      ptr_field = v[`CLBP_FIELD_HI:`CLBP_FIELD_LO];
    end
  endfunction

  wire          cle = host_control_register[`CLBP_CLE_BIT];
  wire [FW-1:0] cur_field;
  wire [FW-1:0] bulk_field;
  reg  [1:0]    state_r;
  reg  [1:0]    state_nxt;
  reg           cur_hw_load;
  reg  [FW-1:0] cur_hw_value;
  wire          at_end = (cur_field == `CLBP_FIELD_RESET);

  // Writes while the list is enabled are dropped to protect the walk
  wire cur_sw_load = reg_wr && !cle &&
                     (reg_addr == `CLBP_OFS_CTRL_CUR);
  // Same priority as the slice, so the outputs track the stored field
  wire [FW-1:0] cur_next = cur_hw_load ? cur_hw_value :
                           (cur_sw_load ? ptr_field(reg_wdata) : cur_field);
  wire bulk_sw_load = reg_wr &&
                      (reg_addr == `CLBP_OFS_BULK_HEAD);
  // Low bits written as zero by software are not stored anyway
  wire [FW-1:0] bulk_wfield = ptr_field(reg_wdata);

  always @*
  begin
    state_nxt    = state_r;
    cur_hw_load  = 1'b0;
    cur_hw_value = cur_field;
    clf_clear    = 1'b0;
    case (state_r)
      `CLBP_ST_IDLE:
      begin
        // No reload to head on a new frame: pointer is kept
        if (cle && frame_start)
          state_nxt = `CLBP_ST_WALK;
      end
      `CLBP_ST_WALK:
      begin
        if (!cle)
          state_nxt = `CLBP_ST_IDLE;
        else if (at_end)
          state_nxt = `CLBP_ST_END;
        else if (ed_served)
        begin
          cur_hw_load  = 1'b1;
          cur_hw_value = ptr_field(ed_next_pointer);
        end
      end
      `CLBP_ST_END:
      begin
        if (control_list_filled)
        begin
          cur_hw_load  = 1'b1;
          cur_hw_value = ptr_field(control_list_head_pointer);
          clf_clear    = 1'b1;
        end
        // Flag clear: pointer and flag stay as they are
        // A frame start here must not be lost, so it is taken directly
        if (cle && frame_start)
          state_nxt = `CLBP_ST_WALK;
        else
          state_nxt = `CLBP_ST_IDLE;
      end
      default:
        state_nxt = `CLBP_ST_IDLE;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (!rst_n)
      state_r <= `CLBP_ST_IDLE;
    else
      state_r <= state_nxt;
  end

  clbp_reg_slice #(.W(FW)) u_cur
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .hw_load  (cur_hw_load),
    .hw_value (cur_hw_value),
    .sw_load  (cur_sw_load),
    .sw_value (ptr_field(reg_wdata)),
    .field_r  (cur_field)
  );

  clbp_reg_slice #(.W(FW)) u_bulk
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .hw_load  (init_load),
    .hw_value (ptr_field(init_bulk_head)),
    .sw_load  (bulk_sw_load),
    .sw_value (bulk_wfield),
    .field_r  (bulk_field)
  );

  // Live value returned, no snapshot
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      reg_rdata        <= `CLBP_PTR_RESET;
      control_ed_addr  <= `CLBP_PTR_RESET;
      bulk_ed_addr     <= `CLBP_PTR_RESET;
      control_list_end <= 1'b1;
      control_active   <= 1'b0;
    end
    else
    begin
      if (reg_rd)
      begin
        if (reg_addr == `CLBP_OFS_CTRL_CUR)
          reg_rdata <= ed_addr(cur_field);
        else if (reg_addr == `CLBP_OFS_BULK_HEAD)
          reg_rdata <= ed_addr(bulk_field);
        else
          reg_rdata <= `CLBP_PTR_RESET;
      end
      control_ed_addr  <= ed_addr(cur_next);
      if (bulk_start)
        bulk_ed_addr <= ed_addr(bulk_field);
      control_list_end <= (cur_next == `CLBP_FIELD_RESET);
      control_active   <= (state_nxt == `CLBP_ST_WALK);
    end
  end

endmodule

// ---- tb/clbp_ed_memory.sv ----
// Behavioural descriptor memory answering next pointers
`timescale 1ns/1ps
module clbp_ed_memory
(
  // Descriptor address in, next pointer out
  input  wire [31:0] ed_addr,
  output wire [31:0] next_ptr
);
  // Three chained descriptors; the last closes the list with zero
  assign next_ptr = (ed_addr == 32'h1000) ? 32'h1040 :
                    (ed_addr == 32'h1040) ? 32'h1080 : 32'h0;
endmodule

// ---- tb/clbp_lp_asserts.sv ----
// Port assertions for the list pointer bank
`timescale 1ns/1ps
module clbp_lp_asserts
(
  input wire core_clk, input wire rst_n, input wire [7:0] reg_addr,
  input wire reg_wr, input wire reg_rd, input wire [31:0] reg_rdata,
  input wire [31:0] host_control_register, input wire clf_clear,
  input wire control_list_filled, input wire ed_served,
  input wire [31:0] control_list_head_pointer, input wire frame_start,
  input wire [31:0] ed_next_pointer, input wire bulk_start,
  input wire init_load, input wire [31:0] init_bulk_head,
  input wire [31:0] control_ed_addr, input wire [31:0] bulk_ed_addr,
  input wire control_list_end, input wire control_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_init_bulk;
    init_load ##1 bulk_start;
  endsequence
  a_live_read: assert property (reg_rd && reg_addr == 8'h24 |=>
    reg_rdata == $past(control_ed_addr)) else $error("read not live");
  a_aligned_addr: assert property (control_ed_addr[3:0] == 4'h0 &&
    bulk_ed_addr[3:0] == 4'h0) else $error("address not aligned");
  a_end_marker: assert property (control_list_end ==
    (control_ed_addr == 32'h0)) else $error("end flag wrong");
  a_wrap_head: assert property (clf_clear |=> control_ed_addr ==
    {$past(control_list_head_pointer[31:4]), 4'h0}) else $error("no wrap");
  a_flag_needed: assert property (clf_clear |->
    control_list_filled && control_list_end) else $error("bad clear");
  a_served_adv: assert property (host_control_register[4] &&
    control_active && ed_served |=> control_ed_addr ==
    {$past(ed_next_pointer[31:4]), 4'h0}) else $error("no advance");
  a_write_refused: assert property (reg_wr && reg_addr == 8'h24 &&
    host_control_register[4] && !control_active && !clf_clear |=>
    $stable(control_ed_addr)) else $error("write taken");
  a_bulk_start: assert property (s_init_bulk |=> bulk_ed_addr ==
    {$past(init_bulk_head[31:4], 2), 4'h0}) else $error("bulk start");
  a_frame_walk: assert property (frame_start && host_control_register[4]
    && !control_active |=> control_active) else $error("no walk");
endmodule
bind clbp_list_pointers clbp_lp_asserts clbp_lp_asserts_inst (.*);

// ---- tb/clbp_list_pointers_tb_top.sv ----
// Self-checking bench for the list pointer bank
`timescale 1ns/1ps
module clbp_list_pointers_tb_top;
  reg core_clk, rst_n, reg_wr, reg_rd, control_list_filled, frame_start;
  reg ed_served, bulk_start, init_load;
  reg [7:0] reg_addr;
  reg [31:0] reg_wdata, host_control_register, init_bulk_head;
  reg [31:0] control_list_head_pointer;
  wire [31:0] reg_rdata, ed_next_pointer, control_ed_addr, bulk_ed_addr;
  wire clf_clear, control_list_end, control_active;
  integer fails = 0;
  integer comparisons = 0;
  clbp_list_pointers clbp_list_pointers_inst (.*);
  clbp_ed_memory clbp_ed_memory_inst (.ed_addr(control_ed_addr),
    .next_ptr(ed_next_pointer));
  task cyc;
    @(posedge core_clk);
    #1;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg_addr = a; reg_wdata = d; reg_wr = 1; cyc; reg_wr = 0;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    reg_addr = a; reg_rd = 1; cyc; reg_rd = 0; chk(reg_rdata, e);
  endtask
  task pulse_frame;
    frame_start = 1; cyc; frame_start = 0;
  endtask
  task serve(input [31:0] e);
    ed_served = 1; cyc; ed_served = 0; chk(control_ed_addr, e);
  endtask
  task finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task t_regs;
    rd(8'h24, 32'h0);
    chk({31'h0, control_list_end}, 32'h1);
    wr(8'h28, 32'h1230);
    rd(8'h28, 32'h1230);
    wr(8'h24, 32'h1000);
    host_control_register = 32'h10;
    wr(8'h24, 32'h2000);
    rd(8'h24, 32'h1000);
    rd(8'h2C, 32'h0);
    $display("register test done");
  endtask
  task t_walk;
    pulse_frame;
    chk({31'h0, control_active}, 32'h1);
    serve(32'h1040);
    pulse_frame;
    chk(control_ed_addr, 32'h1040);
    serve(32'h1080);
    serve(32'h0);
    repeat (3) cyc;
    chk(control_ed_addr, 32'h0);
    control_list_filled = 1;
    pulse_frame;
    repeat (6) if (!clf_clear) cyc;
    chk({31'h0, clf_clear}, 32'h1);
    cyc;
    control_list_filled = 0;
    chk(control_ed_addr, 32'h3000);
    $display("walk test done");
  endtask
  task t_init;
    init_bulk_head = 32'h4560; init_load = 1; cyc; init_load = 0;
    bulk_start = 1; cyc; bulk_start = 0;
    chk(bulk_ed_addr, 32'h4560);
    rd(8'h28, 32'h4560);
    $display("init test done");
  endtask
  initial
  begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  initial
  begin
    #20000 fails = fails + 1;
    finish_test;
  end
  initial
  begin
    {rst_n, reg_wr, reg_rd, control_list_filled, frame_start} = 0;
    {ed_served, bulk_start, init_load, reg_addr, reg_wdata} = 0;
    {host_control_register, init_bulk_head} = 0;
    control_list_head_pointer = 32'h3000;
    repeat (3) @(posedge core_clk);
    #1 rst_n = 1;
    t_regs;
    t_walk;
    t_init;
    finish_test;
  end
endmodule
